// File: core/pms_map.svh
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH

// Register byte offsets
`define PMS_OFF_CTRL 12'h000
`define PMS_OFF_BUCK 12'h004
`define PMS_OFF_WAKE_EN 12'h008
`define PMS_OFF_RST_EN 12'h00C
`define PMS_OFF_RETAIN 12'h010
`define PMS_OFF_CLKGATE 12'h014
`define PMS_OFF_STATUS 12'h018
`define PMS_OFF_FLAGS 12'h01C

// Control register field positions
`define PMS_CTRL_DEEP_SEL 0
`define PMS_CTRL_BUCK_SYNC 1
`define PMS_CTRL_SLOW 2
`define PMS_CTRL_FAST_WAKE 3
`define PMS_CTRL_FAST_RTC 4
`define PMS_CTRL_DRV_SRC 5
`define PMS_CTRL_LDO_SRC 8

// Wake enable register: pin enables low, source enables from here
`define PMS_WAKE_SRC_POS 16

// Wake source vector positions that double as reset sources
`define PMS_WSRC_RTC_OSC 2
`define PMS_WSRC_COMPARATOR_ZERO 3
`define PMS_WSRC_CP_FAIL 7

// Sticky flag positions
`define PMS_FLAG_LOW_BAT 0
`define PMS_FLAG_DEEP_WOKE 1

// Reset values
`define PMS_RST_CTRL 11'h000
`define PMS_RST_BUCK 5'h0B
`define PMS_RST_WAKE_EN 14'h0000
`define PMS_RST_SRC_EN 8'h00
`define PMS_RST_RST_EN 7'h03
`define PMS_RST_RETAIN 8'hFF
`define PMS_RST_CLKGATE 16'hFFFF

// Buck converter target ladder, millivolts (1250, 1800, 50, 100, 450)
`define PMS_BUCK_BASE_MV 13'h04E2
`define PMS_BUCK_KNEE_MV 13'h0708
`define PMS_BUCK_FINE_MV 13'h0032
`define PMS_BUCK_COARSE_MV 13'h0064
`define PMS_BUCK_KNEE_CODE 5'h0B
`define PMS_HEADROOM_MV 13'h01C2

`endif

// File: core/pms_pkg.sv
package pms_pkg;

	// Power manager states, one-hot
	typedef enum logic [4:0] {
		ST_POWERUP = 5'h01,
		ST_RUN = 5'h02,
		ST_LIGHT = 5'h04,
		ST_STOP = 5'h08,
		ST_DEEP = 5'h10
	} pm_state_t;

	typedef logic [4:0] buck_code_t;

endpackage

// File: core/pms_sync.sv
`timescale 1ns/100ps

module pms_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Asynchronous levels in, synchronous copies out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	// Two stages; only the second stage reads the first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule

// File: core/pms_buck_guard.sv
`timescale 1ns/100ps
`include "pms_map.svh"

module pms_buck_guard
	import pms_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Programmed target and measured battery
	input wire buck_code_t code,
	input wire logic [11:0] bat_mv,
	// Bypass request, registered
	output logic bypass_q
);

	// Target in mV: fine steps up to the knee, coarse steps above
	function automatic logic [12:0] target_mv(input buck_code_t c);
		logic [12:0] cc;
		cc = {8'h00, c};
		if (c <= `PMS_BUCK_KNEE_CODE) begin
			target_mv = 13'(`PMS_BUCK_BASE_MV + cc * `PMS_BUCK_FINE_MV);
		end else begin
			target_mv = 13'(`PMS_BUCK_KNEE_MV +
				(cc - {8'h00, `PMS_BUCK_KNEE_CODE}) * `PMS_BUCK_COARSE_MV);
		end
	endfunction

	logic short_headroom;

	// Bypass whenever the battery sits less than the headroom above target
	assign short_headroom = (target_mv(code) + `PMS_HEADROOM_MV) > {1'b0, bat_mv};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bypass_q <= 1'b1;
		end else begin
			bypass_q <= short_headroom;
		end
	end

	a_bypass_follows: assert property (@(posedge clk) disable iff (!rst_n)
		short_headroom |=> bypass_q) else $error("bypass missing without headroom");

	a_bypass_clears: assert property (@(posedge clk) disable iff (!rst_n)
		(code == 5'h00 && bat_mv > 12'h6A4) |=> !bypass_q)
		else $error("bypass held with ample headroom");

endmodule

// File: core/power_mode_sequencer.sv
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "pms_map.svh"

module power_mode_sequencer
	import pms_pkg::*;
#(
	parameter int PIN_WAKES = 14,
	parameter int WAKE_SRCS = 8,
	parameter int RAM_BLOCKS = 8,
	parameter int PERIPHS = 16
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESET_N,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Analog status, asynchronous
	input wire logic [11:0] BAT_MV,
	input wire logic BAT_WARN,
	input wire logic BAT_RESET,
	input wire logic CORE_V_OK,
	// Wake and reset sources, asynchronous
	input wire logic [PIN_WAKES-1:0] PIN_WAKE,
	input wire logic [WAKE_SRCS-1:0] WAKE_SRC,
	input wire logic RST_PIN_N,
	input wire logic CMP1_RST,
	// Core sleep handshake, same clock
	input wire logic SLEEP_REQ,
	input wire logic CORE_DEEP,
	input wire logic IRQ_PEND,
	input wire logic IN_HANDLER,
	input wire logic IRQ_PRIO_OK,
	// Core and clock control
	output logic CORE_RUN,
	output logic CORE_CLK_EN,
	output logic [PERIPHS-1:0] PERIPH_CLK_EN,
	output logic SLOW_CLK_SEL,
	output logic KEEP_LFO_OSC,
	output logic KEEP_RTC_OSC,
	// Supply control
	output logic [4:0] BUCK_TARGET,
	output logic BUCK_BYPASS,
	output logic BUCK_SYNC,
	output logic LDO_EN,
	output logic [2:0] LDO_SRC,
	output logic DRV_SRC,
	output logic CORE_PWR_EN,
	output logic [RAM_BLOCKS-1:0] RAM_PWR,
	// Reset and indicators
	output logic DEV_RESET,
	output logic BAT_LOW_WARN,
	output logic ASLEEP
);

	localparam int SYNC_W = 12 + 3 + PIN_WAKES + WAKE_SRCS + 2;

	logic rst_meta_q;
	logic rst_n;
	logic [SYNC_W-1:0] async_in;
	logic [SYNC_W-1:0] sync_out;
	logic [11:0] bat_mv_s;
	logic warn_s;
	logic bat_reset_s;
	logic v_ok_s;
	logic [PIN_WAKES-1:0] pin_s;
	logic [WAKE_SRCS-1:0] wsrc_s;
	logic pin_rst_s;
	logic cmp1_s;
	pm_state_t state_q;
	pm_state_t state_d;
	logic [10:0] ctrl_q;
	buck_code_t buck_q;
	logic [PIN_WAKES-1:0] pin_en_q;
	logic [WAKE_SRCS-1:0] src_en_q;
	logic [6:0] rst_en_q;
	logic [RAM_BLOCKS-1:0] retain_q;
	logic [PERIPHS-1:0] clkgate_q;
	logic [1:0] flags_q;
	logic [31:0] rdata_d;
	logic hit_d;
	logic wr_en;
	logic wake_evt;
	logic irq_ok;
	logic [6:0] rst_src;
	logic [6:0] rst_hit;
	logic bypass_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic core_run_q;
	logic core_clk_q;
	logic [PERIPHS-1:0] periph_clk_q;
	logic slow_q;
	logic keep_lfo_q;
	logic keep_rtc_q;
	logic ldo_en_q;
	logic core_pwr_q;
	logic [RAM_BLOCKS-1:0] ram_pwr_q;
	logic dev_reset_q;
	logic warn_q;
	logic asleep_q;

	// Reset release through two stages, assertion stays asynchronous
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// All pin-side levels share one synchroniser; the battery code is slow
	assign async_in = {BAT_MV, BAT_WARN, BAT_RESET, CORE_V_OK, PIN_WAKE, WAKE_SRC,
		~RST_PIN_N, CMP1_RST};

	pms_sync #(.WIDTH(SYNC_W)) u_sync (
		.clk(MCLK),
		.rst_n(rst_n),
		.d(async_in),
		.q(sync_out)
	);

	assign {bat_mv_s, warn_s, bat_reset_s, v_ok_s, pin_s, wsrc_s, pin_rst_s, cmp1_s} =
		sync_out;

	// Buck target ladder and headroom watch
	pms_buck_guard u_buck (
		.clk(MCLK),
		.rst_n(rst_n),
		.code(buck_q),
		.bat_mv(bat_mv_s),
		.bypass_q(bypass_q)
	);

	// Wake and reset qualification
	assign wake_evt = (|(pin_s & pin_en_q)) | (|(wsrc_s & src_en_q));
	assign irq_ok = IRQ_PEND & (!IN_HANDLER | IRQ_PRIO_OK);
	assign rst_src = {wake_evt, wsrc_s[`PMS_WSRC_RTC_OSC], wsrc_s[`PMS_WSRC_CP_FAIL],
		cmp1_s, wsrc_s[`PMS_WSRC_COMPARATOR_ZERO], bat_reset_s, pin_rst_s};
	assign rst_hit = rst_src & rst_en_q;

	// Mode sequencing; a low battery overrides every state
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_POWERUP: begin
				if (v_ok_s) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (SLEEP_REQ) begin
					if (!CORE_DEEP) begin
						state_d = ST_LIGHT;
					end else if (ctrl_q[`PMS_CTRL_DEEP_SEL]) begin
						state_d = ST_DEEP;
					end else begin
						state_d = ST_STOP;
					end
				end
			end
			ST_LIGHT: begin
				if (irq_ok) begin
					state_d = ST_RUN;
				end
			end
			ST_STOP: begin
				if (irq_ok || wake_evt || (|rst_hit)) begin
					state_d = ST_RUN;
				end
			end
			ST_DEEP: begin
				if (|rst_hit) begin
					state_d = ST_POWERUP;
				end
			end
			default: begin
				state_d = ST_POWERUP;
			end
		endcase
		if (bat_reset_s) begin
			state_d = ST_POWERUP;
		end
	end

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_POWERUP;
		end else begin
			state_q <= state_d;
		end
	end

	// Power and clock outputs from the current state
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			core_run_q <= 1'b0;
			core_clk_q <= 1'b0;
			periph_clk_q <= '0;
			slow_q <= 1'b0;
			keep_lfo_q <= 1'b0;
			keep_rtc_q <= 1'b0;
			ldo_en_q <= 1'b1;
			core_pwr_q <= 1'b1;
			ram_pwr_q <= '1;
			asleep_q <= 1'b0;
		end else begin
			core_run_q <= (state_q == ST_RUN);
			core_clk_q <= (state_q == ST_RUN);
			if (state_q == ST_RUN || state_q == ST_LIGHT) begin
				periph_clk_q <= clkgate_q;
			end else begin
				periph_clk_q <= '0;
			end
			// Slow select changes only the rate, never the mode behaviour
			slow_q <= ctrl_q[`PMS_CTRL_SLOW];
			keep_lfo_q <= (state_q == ST_STOP) && ctrl_q[`PMS_CTRL_FAST_WAKE] &&
				!ctrl_q[`PMS_CTRL_FAST_RTC];
			keep_rtc_q <= (state_q == ST_STOP) && ctrl_q[`PMS_CTRL_FAST_WAKE] &&
				ctrl_q[`PMS_CTRL_FAST_RTC];
			ldo_en_q <= (state_q != ST_DEEP);
			core_pwr_q <= (state_q != ST_DEEP);
			ram_pwr_q <= (state_q == ST_DEEP) ? retain_q : '1;
			asleep_q <= (state_q == ST_DEEP);
		end
	end

	// Supply monitor outputs
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			dev_reset_q <= 1'b1;
			warn_q <= 1'b0;
		end else begin
			dev_reset_q <= bat_reset_s || (state_q == ST_POWERUP);
			warn_q <= warn_s;
		end
	end

	// APB decode helper
	function automatic logic at(input logic [11:0] a, input logic [11:0] off);
		at = (a == off);
	endfunction

	// Write is taken in the access cycle, which the slave always completes
	assign wr_en = PSEL && PENABLE && PWRITE && pready_q;

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= `PMS_RST_CTRL;
			buck_q <= `PMS_RST_BUCK;
			pin_en_q <= `PMS_RST_WAKE_EN;
			src_en_q <= `PMS_RST_SRC_EN;
			rst_en_q <= `PMS_RST_RST_EN;
			retain_q <= `PMS_RST_RETAIN;
			clkgate_q <= `PMS_RST_CLKGATE;
		end else if (wr_en) begin
			if (at(PADDR, `PMS_OFF_CTRL)) begin
				ctrl_q <= PWDATA[10:0];
			end
			if (at(PADDR, `PMS_OFF_BUCK)) begin
				buck_q <= PWDATA[4:0];
			end
			if (at(PADDR, `PMS_OFF_WAKE_EN)) begin
				pin_en_q <= PWDATA[PIN_WAKES-1:0];
				src_en_q <= PWDATA[`PMS_WAKE_SRC_POS +: WAKE_SRCS];
			end
			if (at(PADDR, `PMS_OFF_RST_EN)) begin
				rst_en_q <= PWDATA[6:0];
			end
			if (at(PADDR, `PMS_OFF_RETAIN)) begin
				retain_q <= PWDATA[RAM_BLOCKS-1:0];
			end
			if (at(PADDR, `PMS_OFF_CLKGATE)) begin
				clkgate_q <= PWDATA[PERIPHS-1:0];
			end
		end
	end

	// Sticky flags, write one to clear; a new event beats the clear
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= 2'h0;
		end else begin
			flags_q[`PMS_FLAG_LOW_BAT] <= warn_s || (flags_q[`PMS_FLAG_LOW_BAT] &&
				!(wr_en && at(PADDR, `PMS_OFF_FLAGS) && PWDATA[`PMS_FLAG_LOW_BAT]));
			flags_q[`PMS_FLAG_DEEP_WOKE] <= (state_q == ST_DEEP && state_d == ST_POWERUP) ||
				(flags_q[`PMS_FLAG_DEEP_WOKE] &&
				!(wr_en && at(PADDR, `PMS_OFF_FLAGS) && PWDATA[`PMS_FLAG_DEEP_WOKE]));
		end
	end

	// Read mux; unmapped addresses answer zero with an error
	always_comb begin
		rdata_d = 32'h0000_0000;
		hit_d = 1'b1;
		case (PADDR)
			`PMS_OFF_CTRL: rdata_d[10:0] = ctrl_q;
			`PMS_OFF_BUCK: rdata_d[4:0] = buck_q;
			`PMS_OFF_WAKE_EN: begin
				rdata_d[PIN_WAKES-1:0] = pin_en_q;
				rdata_d[`PMS_WAKE_SRC_POS +: WAKE_SRCS] = src_en_q;
			end
			`PMS_OFF_RST_EN: rdata_d[6:0] = rst_en_q;
			`PMS_OFF_RETAIN: rdata_d[RAM_BLOCKS-1:0] = retain_q;
			`PMS_OFF_CLKGATE: rdata_d[PERIPHS-1:0] = clkgate_q;
			`PMS_OFF_STATUS: rdata_d[8:0] = {v_ok_s, bat_reset_s, warn_s, bypass_q, state_q};
			`PMS_OFF_FLAGS: rdata_d[1:0] = flags_q;
			default: hit_d = 1'b0;
		endcase
	end

	// One wait-free access cycle after every setup cycle
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= PSEL && !PENABLE;
			pslverr_q <= PSEL && !PENABLE && !hit_d;
			if (PSEL && !PENABLE && !PWRITE) begin
				prdata_q <= rdata_d;
			end
		end
	end

	// Ports straight from flip-flops
	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign CORE_RUN = core_run_q;
	assign CORE_CLK_EN = core_clk_q;
	assign PERIPH_CLK_EN = periph_clk_q;
	assign SLOW_CLK_SEL = slow_q;
	assign KEEP_LFO_OSC = keep_lfo_q;
	assign KEEP_RTC_OSC = keep_rtc_q;
	assign BUCK_TARGET = buck_q;
	assign BUCK_BYPASS = bypass_q;
	assign BUCK_SYNC = ctrl_q[`PMS_CTRL_BUCK_SYNC];
	assign LDO_EN = ldo_en_q;
	assign LDO_SRC = ctrl_q[`PMS_CTRL_LDO_SRC +: 3];
	assign DRV_SRC = ctrl_q[`PMS_CTRL_DRV_SRC];
	assign CORE_PWR_EN = core_pwr_q;
	assign RAM_PWR = ram_pwr_q;
	assign DEV_RESET = dev_reset_q;
	assign BAT_LOW_WARN = warn_q;
	assign ASLEEP = asleep_q;

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!rst_n);

	sequence deep_request;
		state_q == ST_RUN && !bat_reset_s && SLEEP_REQ && CORE_DEEP;
	endsequence

	sequence deep_quiet;
		state_q == ST_DEEP && !bat_reset_s && !(|rst_hit);
	endsequence

	a_deep_entry: assert property (
		deep_request and ctrl_q[`PMS_CTRL_DEEP_SEL] |=> state_q == ST_DEEP ##1 asleep_q)
		else $error("deep select did not reach deepest sleep");

	a_stop_entry: assert property (
		deep_request and !ctrl_q[`PMS_CTRL_DEEP_SEL] |=> state_q == ST_STOP ##1 !core_clk_q)
		else $error("clear select did not reach stop");

	a_light_halt: assert property (
		state_q == ST_LIGHT |=> !core_clk_q && periph_clk_q == $past(clkgate_q))
		else $error("light sleep clocks wrong");

	a_deep_stays: assert property (deep_quiet |=> state_q == ST_DEEP)
		else $error("left deepest sleep without enabled reset");

	a_deep_power: assert property (
		state_q == ST_DEEP |=> !ldo_en_q && !core_pwr_q && ram_pwr_q == $past(retain_q))
		else $error("deepest sleep power state wrong");

	a_powerup_hold: assert property (
		state_q == ST_POWERUP && !v_ok_s |=> state_q == ST_POWERUP ##1 !core_run_q)
		else $error("core released before supplies valid");

	a_bat_reset: assert property (bat_reset_s |=> dev_reset_q && state_q == ST_POWERUP)
		else $error("reset not held on low battery");

	a_handler_wake: assert property (
		state_q == ST_LIGHT && !bat_reset_s && IN_HANDLER && !IRQ_PRIO_OK |=> state_q == ST_LIGHT)
		else $error("woke on unrecognised priority");

	a_pin_wake: assert property (
		state_q == ST_STOP && !bat_reset_s && (|(pin_s & pin_en_q)) |=> state_q == ST_RUN)
		else $error("enabled pin wake ignored");

	a_low_warn: assert property (warn_s |=> warn_q && flags_q[`PMS_FLAG_LOW_BAT])
		else $error("low battery warning missing");

	a_stop_fast: assert property (
		state_q == ST_STOP && ctrl_q[`PMS_CTRL_FAST_WAKE] |=> keep_lfo_q || keep_rtc_q)
		else $error("fast wake oscillator not kept");

endmodule

// File: dv/pms_core_model.sv
`timescale 1ns/100ps

module pms_core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Core state and firmware commands
	input wire logic core_run,
	input wire logic cmd,
	input wire logic deep,
	input wire logic cfg_done,
	// Sleep handshake towards the power manager
	output logic sleep_req,
	output logic core_deep
);
	// Only a running core executes a sleep instruction, one pulse per command
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_req <= 1'b0;
		end else begin
			sleep_req <= cmd && core_run && cfg_done && !sleep_req;
		end
	end
	// Deep flag is set on the same edge as the sleep request and then held, like a control bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			core_deep <= 1'b0;
		end else if (cmd) begin
			core_deep <= deep;
		end
	end
endmodule

// File: dv/power_mode_sequencer_bench.sv
`timescale 1ns/100ps

module power_mode_sequencer_bench;
	import pms_pkg::*;
	// Bench wiring
	logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err_q, saw_rst;
	logic bat_warn, bat_reset, core_v_ok, rst_pin_n, cmp1_rst, in_handler, irq_pend;
	logic irq_prio_ok, sleep_cmd, deep_cmd, cfg_done, sleep_req, core_deep;
	logic [11:0] paddr, bat_mv;
	logic [31:0] pwdata, prdata, rd_q;
	logic [13:0] pin_wake;
	logic [7:0] wake_src, ram_pwr;
	logic core_run, core_clk_en, slow_clk_sel, keep_lfo, keep_rtc, buck_bypass, buck_sync;
	logic ldo_en, drv_src, core_pwr_en, dev_reset, bat_low_warn, asleep;
	logic [15:0] periph_clk_en;
	logic [4:0] buck_target;
	logic [2:0] ldo_src;
	int error_cnt, checks_done, mv, r, p;
	int codes [5] = '{0, 11, 12, 29, 0};
	// Reference register image and writable masks
	int exp_reg [6] = '{0, 32'h0000_000B, 0, 32'h0000_0003, 32'h0000_00FF, 32'h0000_FFFF};
	int mask [6] = '{32'h0000_07FF, 32'h0000_001F, 32'h00FF_3FFF, 32'h0000_007F,
		32'h0000_00FF, 32'h0000_FFFF};

	power_mode_sequencer dut (
		.MCLK(mclk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.BAT_MV(bat_mv), .BAT_WARN(bat_warn), .BAT_RESET(bat_reset), .CORE_V_OK(core_v_ok),
		.PIN_WAKE(pin_wake), .WAKE_SRC(wake_src), .RST_PIN_N(rst_pin_n), .CMP1_RST(cmp1_rst),
		.SLEEP_REQ(sleep_req), .CORE_DEEP(core_deep), .IRQ_PEND(irq_pend),
		.IN_HANDLER(in_handler), .IRQ_PRIO_OK(irq_prio_ok), .CORE_RUN(core_run),
		.CORE_CLK_EN(core_clk_en), .PERIPH_CLK_EN(periph_clk_en), .SLOW_CLK_SEL(slow_clk_sel),
		.KEEP_LFO_OSC(keep_lfo), .KEEP_RTC_OSC(keep_rtc), .BUCK_TARGET(buck_target),
		.BUCK_BYPASS(buck_bypass), .BUCK_SYNC(buck_sync), .LDO_EN(ldo_en), .LDO_SRC(ldo_src),
		.DRV_SRC(drv_src), .CORE_PWR_EN(core_pwr_en), .RAM_PWR(ram_pwr),
		.DEV_RESET(dev_reset), .BAT_LOW_WARN(bat_low_warn), .ASLEEP(asleep));

	pms_core_model core (.clk(mclk), .rst_n(reset_n), .core_run(core_run), .cmd(sleep_cmd),
		.deep(deep_cmd), .cfg_done(cfg_done), .sleep_req(sleep_req), .core_deep(core_deep));

	// Free-running system clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Remembers that the device reset was seen while leaving deep sleep
	always @(posedge mclk) begin
		if (dev_reset === 1'b1) saw_rst <= 1'b1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Lets n edges pass, then looks at settled outputs between edges
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(negedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) error_cnt++;
		@(posedge mclk);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		if (a < 12'h018) exp_reg[a[4:2]] = d & mask[a[4:2]];
	endtask

	task automatic wait_run();
		int n;
		n = 0;
		while (core_run !== 1'b1 && n < 200) begin
			@(negedge mclk);
			n++;
		end
	endtask

	task automatic sleep(input logic d);
		@(posedge mclk);
		sleep_cmd <= 1'b1;
		deep_cmd <= d;
		@(posedge mclk);
		sleep_cmd <= 1'b0;
		settle(3);
	endtask

	// Hang guard, well beyond the roughly one thousand cycles the sequence needs
	initial begin
		#200000;
		error_cnt++;
		give_verdict();
	end

	initial begin
		{reset_n, psel, penable, pwrite, paddr, pwdata, bat_warn, bat_reset} = '0;
		{core_v_ok, cmp1_rst, in_handler, irq_pend, irq_prio_ok, pin_wake, wake_src} = '0;
		{sleep_cmd, deep_cmd, cfg_done, saw_rst, error_cnt, checks_done} = '0;
		rst_pin_n = 1'b1;
		bat_mv = 12'hFFF;
		r = $urandom(25544);
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		// Core held while its supplies are not yet valid
		settle(8);
		chk(core_run, 1'b0);
		chk(dev_reset, 1'b1);
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 12'(i * 4), 0);
			chk(rd_q, exp_reg[i]);
		end
		apb(1'b0, 12'h020, 0);
		chk(err_q, 1'b1);
		chk(rd_q, 0);
		@(posedge mclk);
		core_v_ok <= 1'b1;
		wait_run();
		settle(2);
		chk(core_run, 1'b1);
		chk(dev_reset, 1'b0);
		// Random register images reach the supply and clock controls
		for (int i = 0; i < 6; i++) begin
			wr(12'(i * 4), $urandom);
			apb(1'b0, 12'(i * 4), 0);
			chk(rd_q, exp_reg[i]);
		end
		settle(2);
		chk(buck_target, exp_reg[1]);
		chk(buck_sync, exp_reg[0][1]);
		chk(ldo_src, exp_reg[0][10:8]);
		chk(drv_src, exp_reg[0][5]);
		chk(periph_clk_en, exp_reg[5]);
		chk(slow_clk_sel, exp_reg[0][2]);
		// Bypass exactly at the headroom edge, across both step sizes
		codes[4] = $urandom_range(29, 0);
		for (int k = 0; k < 5; k++) begin
			mv = codes[k] <= 11 ? 1250 + 50 * codes[k] : 1800 + 100 * (codes[k] - 11);
			wr(12'h004, codes[k]);
			for (int b = -1; b < 2; b++) begin
				@(posedge mclk);
				bat_mv <= 12'(mv + 450 - b);
				settle(5);
				chk(buck_bypass, b > 0);
			end
		end
		// Low battery warning and its sticky flag
		@(posedge mclk);
		bat_warn <= 1'b1;
		settle(4);
		chk(bat_low_warn, 1'b1);
		@(posedge mclk);
		bat_warn <= 1'b0;
		settle(4);
		chk(bat_low_warn, 1'b0);
		apb(1'b0, 12'h01C, 0);
		chk(rd_q[0], 1'b1);
		wr(12'h01C, 1);
		apb(1'b0, 12'h01C, 0);
		chk(rd_q[0], 1'b0);
		// Battery below reset holds the device in reset
		@(posedge mclk);
		bat_reset <= 1'b1;
		settle(25);
		chk(dev_reset, 1'b1);
		chk(core_run, 1'b0);
		@(posedge mclk);
		bat_reset <= 1'b0;
		wait_run();
		chk(core_run, 1'b1);
		@(posedge mclk);
		cfg_done <= 1'b1;
		wr(12'h014, $urandom);
		// Light sleep at both speeds, sleep issued inside a handler
		for (int s = 0; s < 2; s++) begin
			wr(12'h000, s << 2);
			@(posedge mclk);
			in_handler <= 1'b1;
			sleep(1'b0);
			chk(core_run, 1'b0);
			chk(periph_clk_en, exp_reg[5]);
			chk(slow_clk_sel, s);
			@(posedge mclk);
			irq_pend <= 1'b1;
			settle(6);
			chk(core_run, 1'b0);
			@(posedge mclk);
			irq_prio_ok <= 1'b1;
			wait_run();
			chk(core_run, 1'b1);
			@(posedge mclk);
			{irq_pend, irq_prio_ok, in_handler} <= 3'b000;
		end
		// Stop mode, each wake source alone, a disabled one first
		wr(12'h00C, 0);
		for (int j = 0; j < 8; j++) begin
			wr(12'h000, 32'h0000_0008 | ((j % 2) << 4));
			wr(12'h008, 1 << (16 + j));
			sleep(1'b1);
			chk(asleep, 1'b0);
			chk(core_clk_en, 1'b0);
			chk(periph_clk_en, 0);
			chk(keep_lfo, 1 - j % 2);
			chk(keep_rtc, j % 2);
			@(posedge mclk);
			wake_src <= 8'(1 << ((j + 1) % 8));
			settle(6);
			chk(core_run, 1'b0);
			@(posedge mclk);
			wake_src <= 8'(1 << j);
			wait_run();
			chk(core_run, 1'b1);
			@(posedge mclk);
			wake_src <= 8'h00;
		end
		// Stop mode left by an enabled pin wake, a disabled pin first
		p = $urandom_range(13, 0);
		wr(12'h008, 1 << p);
		sleep(1'b1);
		@(posedge mclk);
		pin_wake <= 14'(1 << ((p + 1) % 14));
		settle(6);
		chk(core_run, 1'b0);
		@(posedge mclk);
		pin_wake <= 14'(1 << p);
		wait_run();
		chk(core_run, 1'b1);
		@(posedge mclk);
		pin_wake <= 14'h0000;
		// Deepest sleep, each reset source alone, a disabled one first
		for (int i = 0; i < 7; i++) begin
			p = $urandom_range(13, 0);
			r = $urandom_range(255, 0);
			wr(12'h010, r);
			wr(12'h00C, 1 << i);
			wr(12'h008, i == 6 ? 1 << p : 0);
			wr(12'h000, 1);
			sleep(1'b1);
			chk(asleep, 1'b1);
			chk(ldo_en, 1'b0);
			chk(core_pwr_en, 1'b0);
			chk(ram_pwr, r);
			chk(dev_reset, 1'b0);
			@(posedge mclk);
			if (i == 3) wake_src <= 8'h08;
			else cmp1_rst <= 1'b1;
			settle(6);
			chk(asleep, 1'b1);
			@(posedge mclk);
			wake_src <= 8'h00;
			cmp1_rst <= 1'b0;
			saw_rst = 1'b0;
			@(posedge mclk);
			case (i)
				0: rst_pin_n <= 1'b0;
				1: bat_reset <= 1'b1;
				2: wake_src <= 8'h08;
				3: cmp1_rst <= 1'b1;
				4: wake_src <= 8'h80;
				5: wake_src <= 8'h04;
				default: pin_wake <= 14'(1 << p);
			endcase
			settle(6);
			@(posedge mclk);
			{rst_pin_n, bat_reset, cmp1_rst, wake_src, pin_wake} <= {1'b1, 24'h0};
			wait_run();
			chk(saw_rst, 1'b1);
			chk(core_run, 1'b1);
			apb(1'b0, 12'h010, 0);
			chk(rd_q, exp_reg[4]);
		end
		give_verdict();
	end
endmodule
